// file: src/aes_cfg.svh
`ifndef AES_CFG_SVH
`define AES_CFG_SVH

// ==========================================================
// Direct register addresses
`define AES_ADDR_CTRL 8'h6e
`define AES_ADDR_OFS 8'h6f
`define AES_ADDR_DATA 8'ha0

// ==========================================================
// Indirect control fields
`define AES_TBL_MSB 7
`define AES_TBL_LSB 5
`define AES_PORT_MSB 3
`define AES_PORT_LSB 0
`define AES_TBL_EEE 3'h1
`define AES_PORT_FIRST 4'h3
`define AES_PORT_LAST 4'h4

// ==========================================================
// Indirect offsets of the status register
`define AES_OFS_STAT_HI 8'h0c
`define AES_OFS_STAT_LO 8'h0d

// ==========================================================
// Status bit positions
`define AES_BIT_LOC_ABLE 6
`define AES_BIT_LOC 5
`define AES_BIT_PD_FAULT 4
`define AES_BIT_LP_NP 3
`define AES_BIT_NP_ABLE 2
`define AES_BIT_PAGE 1
`define AES_BIT_LP_AN 0

// ==========================================================
// Reset values
`define AES_CTRL_RST 8'h00
`define AES_OFS_RST 8'h00
`define AES_STAT_RST 16'h0064
`endif

// file: src/aes_pkg.sv
package aes_pkg;
  typedef logic [7:0] aes_byte_t;
  typedef logic [15:0] aes_stat_t;
endpackage : aes_pkg

// file: src/aes_stat_if.sv
`timescale 1ns/1ps
interface aes_stat_if;
  logic fault_ev;
  logic page_ev;
  logic lp_np_able;
  logic lp_an_able;
  logic rd_clr;
  aes_pkg::aes_stat_t status;
  modport port (
    input fault_ev, page_ev, lp_np_able, lp_an_able, rd_clr,
    output status
  );
  modport ctrl (
    output fault_ev, page_ev, lp_np_able, lp_an_able, rd_clr,
    input status
  );
endinterface : aes_stat_if

// file: src/aes_port_stat.sv
`timescale 1ns/1ps
`include "aes_cfg.svh"
module aes_port_stat (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  aes_stat_if.port st // Events in, status out
);
  import aes_pkg::*;

  logic pd_fault;
  logic page_rcvd;
  logic lp_np;
  logic lp_an;
  logic next_pd_fault;
  logic next_page_rcvd;
  logic next_lp_np;
  logic next_lp_an;

  // ==========================================================
  // Latch-high fault and page flags, set beats read clear; partner bits follow their inputs
  always_comb begin
    next_pd_fault = st.fault_ev | (pd_fault & ~st.rd_clr);
    next_page_rcvd = st.page_ev | (page_rcvd & ~st.rd_clr);
    next_lp_np = st.lp_np_able;
    next_lp_an = st.lp_an_able;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_fault <= 1'b0;
      page_rcvd <= 1'b0;
      lp_np <= 1'b0;
      lp_an <= 1'b0;
    end else begin
      pd_fault <= next_pd_fault;
      page_rcvd <= next_page_rcvd;
      lp_np <= next_lp_np;
      lp_an <= next_lp_an;
    end
  end

  // ==========================================================
  // Status word assembly
  always_comb begin
    st.status = `AES_STAT_RST;
    st.status[`AES_BIT_PD_FAULT] = pd_fault;
    st.status[`AES_BIT_LP_NP] = lp_np;
    st.status[`AES_BIT_PAGE] = page_rcvd;
    st.status[`AES_BIT_LP_AN] = lp_an;
  end
endmodule : aes_port_stat

// file: src/aes_regs.sv
`timescale 1ns/1ps
`include "aes_cfg.svh"
module aes_regs #(
  parameter int NPORT = 2 // Ports with a status copy
) (
  input wire logic CORE_CLK_I, // System clock
  input wire logic RSTN_I, // Async reset, active low
  input wire aes_pkg::aes_byte_t REG_ADDR_I, // Register address
  input wire aes_pkg::aes_byte_t REG_WDATA_I, // Write data
  input wire logic REG_WR_I, // Write strobe
  input wire logic REG_RD_I, // Read strobe
  output aes_pkg::aes_byte_t REG_RDATA_O, // Read data, one cycle later
  output logic REG_RVALID_O, // Read data valid pulse
  input wire logic [NPORT-1:0] PD_FAULT_I, // Parallel fault pulse
  input wire logic [NPORT-1:0] PAGE_RCVD_I, // New page pulse
  input wire logic [NPORT-1:0] LP_NP_ABLE_I, // Partner next-page able
  input wire logic [NPORT-1:0] LP_AN_ABLE_I // Partner autoneg able
);
  import aes_pkg::*;

  // ==========================================================
  // Register state
  aes_byte_t ctrl;
  aes_byte_t ofs;
  aes_byte_t rdata;
  logic rvalid;
  aes_byte_t next_ctrl;
  aes_byte_t next_ofs;
  aes_byte_t next_rdata;
  logic next_rvalid;

  // ==========================================================
  // Decoded strobes and selected port
  logic wr_ctrl;
  logic wr_ofs;
  logic rd_data;
  logic port_ok;
  logic [NPORT-1:0] port_hit; // One-hot, empty when target invalid
  logic [NPORT-1:0] rd_clr;
  aes_stat_t sel_stat;
  wire aes_stat_t stat_arr [NPORT]; // One status word per port copy

  // ==========================================================
  // Indirect target decode
  function automatic logic target_ok(input aes_byte_t c);
    target_ok = (c[`AES_TBL_MSB:`AES_TBL_LSB] == `AES_TBL_EEE) &&
                (c[`AES_PORT_MSB:`AES_PORT_LSB] >= `AES_PORT_FIRST) &&
                (c[`AES_PORT_MSB:`AES_PORT_LSB] <= `AES_PORT_LAST);
  endfunction : target_ok

  function automatic logic [3:0] port_idx(input aes_byte_t c);
    port_idx = c[`AES_PORT_MSB:`AES_PORT_LSB] - `AES_PORT_FIRST;
  endfunction : port_idx

  // Table and port both valid, and the port has a copy
  function automatic logic port_valid(input aes_byte_t c);
    port_valid = target_ok(c) && (port_idx(c) < 4'(NPORT));
  endfunction : port_valid

  function automatic logic addr_hit(input logic s, input aes_byte_t a, input aes_byte_t m);
    addr_hit = s && (a == m);
  endfunction : addr_hit

  // Byte of a status word at an indirect offset
  function automatic aes_byte_t status_byte(input aes_stat_t w, input aes_byte_t o);
    case (o)
      `AES_OFS_STAT_HI: begin
        status_byte = w[15:8];
      end
      `AES_OFS_STAT_LO: begin
        status_byte = w[7:0];
      end
      default: begin
        status_byte = 8'h00;
      end
    endcase
  endfunction : status_byte

  // Only the low byte carries the latched flags
  function automatic logic clears_latches(input aes_byte_t o);
    clears_latches = (o == `AES_OFS_STAT_LO);
  endfunction : clears_latches

  // ==========================================================
  // Per-port status copies
  // Event inputs share this clock, so no synchroniser
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    aes_stat_if st ();
    assign st.fault_ev = PD_FAULT_I[g];
    assign st.page_ev = PAGE_RCVD_I[g];
    assign st.lp_np_able = LP_NP_ABLE_I[g];
    assign st.lp_an_able = LP_AN_ABLE_I[g];
    assign st.rd_clr = rd_clr[g];
    assign stat_arr[g] = st.status;
    aes_port_stat u_stat (
      .clk_i(CORE_CLK_I),
      .rstn_i(RSTN_I),
      .st(st.port)
    );
  end

  // ==========================================================
  // Access decode
  always_comb begin
    // Data register and unmapped addresses take no writes
    wr_ctrl = addr_hit(REG_WR_I, REG_ADDR_I, `AES_ADDR_CTRL);
    wr_ofs = addr_hit(REG_WR_I, REG_ADDR_I, `AES_ADDR_OFS);
    rd_data = addr_hit(REG_RD_I, REG_ADDR_I, `AES_ADDR_DATA);
  end

  // Port select from the control register
  always_comb begin
    // Control bit 4 is not decoded
    port_ok = port_valid(ctrl);
    for (int i = 0; i < NPORT; i++) begin
      port_hit[i] = port_ok && (port_idx(ctrl) == 4'(i));
    end
  end

  // Status word of the addressed port, zero otherwise
  always_comb begin
    sel_stat = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (port_hit[i]) begin
        sel_stat = stat_arr[i];
      end
    end
  end

  // Read of the low byte clears that port's flags
  always_comb begin
    // Same-cycle event still wins in the port copy
    rd_clr = '0;
    if (rd_data && clears_latches(ofs)) begin
      rd_clr = port_hit;
    end
  end

  // ==========================================================
  // Control register, whole byte kept and read back
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = REG_WDATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl <= `AES_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================
  // Offset register
  always_comb begin
    // Unknown offsets are kept and read as zero
    next_ofs = ofs;
    if (wr_ofs) begin
      next_ofs = REG_WDATA_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ofs <= `AES_OFS_RST;
    end else begin
      ofs <= next_ofs;
    end
  end

  // ==========================================================
  // Read valid pulse, one cycle after the strobe
  always_comb begin
    // Refused reads answer too, with zero data
    next_rvalid = REG_RD_I;
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= next_rvalid;
    end
  end

  // ==========================================================
  // Read data, zero when no read
  always_comb begin
    next_rdata = 8'h00;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `AES_ADDR_CTRL: begin
          next_rdata = ctrl;
        end
        `AES_ADDR_OFS: begin
          next_rdata = ofs;
        end
        `AES_ADDR_DATA: begin
          next_rdata = status_byte(sel_stat, ofs);
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Outputs straight from the flops
  assign REG_RDATA_O = rdata;
  assign REG_RVALID_O = rvalid;
endmodule : aes_regs

// file: tb/aes_regs_chk.sv
`timescale 1ns/1ps
module aes_regs_chk #(parameter int NPORT = 2) (
  input wire logic CORE_CLK_I, // Clock
  input wire logic RSTN_I, // Reset
  input wire aes_pkg::aes_byte_t REG_ADDR_I, // Address
  input wire aes_pkg::aes_byte_t REG_WDATA_I, // Wdata
  input wire logic REG_WR_I, // Write
  input wire logic REG_RD_I, // Read
  input wire aes_pkg::aes_byte_t REG_RDATA_O, // Rdata
  input wire logic REG_RVALID_O, // Rvalid
  input wire logic [NPORT-1:0] PD_FAULT_I, // Fault
  input wire logic [NPORT-1:0] PAGE_RCVD_I, // Page
  input wire logic [NPORT-1:0] LP_NP_ABLE_I, // Np
  input wire logic [NPORT-1:0] LP_AN_ABLE_I // An
);
  import aes_pkg::*;
  // ==========
  // Shadow of control and offset
  aes_byte_t ctl;
  aes_byte_t ofs;
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctl <= 8'h00;
      ofs <= 8'h00;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == 8'h6e) ctl <= REG_WDATA_I;
      if (REG_ADDR_I == 8'h6f) ofs <= REG_WDATA_I;
    end
  end
  wire rd = REG_RD_I && REG_ADDR_I == 8'ha0;
  wire lo3 = rd && ctl == 8'h23 && ofs == 8'h0d;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  rvalid_pulse_a: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("rvalid");
  idle_quiet_a: assert property (!REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 8'h00)
    else $error("idle");
  bad_table_a: assert property (rd && ctl[7:5] != 3'h1 |=> REG_RDATA_O == 8'h00)
    else $error("table");
  bad_port_a: assert property (rd && !(ctl[3:0] inside {4'h3, 4'h4}) |=> REG_RDATA_O == 8'h00)
    else $error("port");
  high_byte_a: assert property (rd && ofs == 8'h0c |=> REG_RDATA_O == 8'h00)
    else $error("high");
  const_bits_a: assert property (lo3 |=> REG_RDATA_O[7:5] == 3'h3 && REG_RDATA_O[2])
    else $error("const");
  fault_latch_a: assert property (PD_FAULT_I[0] ##1 lo3 |=> REG_RDATA_O[4])
    else $error("fault");
  page_latch_a: assert property (PAGE_RCVD_I[0] ##1 lo3 |=> REG_RDATA_O[1])
    else $error("page");
  cover property (lo3);
  cover property (PD_FAULT_I[0] ##1 lo3);
  cover property (rd && ofs == 8'h0c);
endmodule : aes_regs_chk
bind aes_regs aes_regs_chk #(.NPORT(NPORT)) chk_u (
  .CORE_CLK_I(CORE_CLK_I),
  .RSTN_I(RSTN_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O),
  .REG_RVALID_O(REG_RVALID_O),
  .PD_FAULT_I(PD_FAULT_I),
  .PAGE_RCVD_I(PAGE_RCVD_I),
  .LP_NP_ABLE_I(LP_NP_ABLE_I),
  .LP_AN_ABLE_I(LP_AN_ABLE_I)
);

// file: tb/aes_regs_tb_top.sv
`timescale 1ns/1ps
module aes_regs_tb_top;
  import aes_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  aes_byte_t addr = 8'h00;
  aes_byte_t wd = 8'h00;
  aes_byte_t rdata;
  logic rv;
  logic [1:0] fi = 2'b00;
  logic [1:0] pi = 2'b00;
  logic [1:0] np = 2'b00;
  logic [1:0] an = 2'b00;
  logic [1:0] flt = 2'b00;
  logic [1:0] pg = 2'b00;
  logic [7:0] rnd = 8'h58;
  aes_byte_t cr = 8'h00;
  int n_errors = 0;
  int n_checks = 0;
  aes_regs #(.NPORT(2)) dut_u (.CORE_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rv),
    .PD_FAULT_I(fi), .PAGE_RCVD_I(pi), .LP_NP_ABLE_I(np), .LP_AN_ABLE_I(an));
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic port_sel(input aes_byte_t c);
    return (c[7:5] == 3'h1) && (c[3:0] inside {4'h3, 4'h4});
  endfunction : port_sel
  function automatic aes_byte_t expect_byte(input aes_byte_t c, input aes_byte_t o);
    int k;
    k = (c[3:0] == 4'h4) ? 1 : 0;
    if (!port_sel(c) || o != 8'h0d) return 8'h00;
    return {3'h3, flt[k], np[k], 1'b1, pg[k], an[k]};
  endfunction : expect_byte
  task automatic check_byte(input string what, input aes_byte_t exp, input aes_byte_t got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic xfer(input logic w, input aes_byte_t a, input aes_byte_t d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    if (!w) check_byte("rdata", d, rdata);
    if (!w) check_bit("rvalid", 1'b1, rv);
  endtask : xfer
  task automatic access(input aes_byte_t c, input aes_byte_t o);
    xfer(1'b1, 8'h6e, c);
    xfer(1'b1, 8'h6f, o);
    xfer(1'b0, 8'ha0, expect_byte(c, o));
    if (port_sel(c) && o == 8'h0d) begin
      flt[c[3:0] == 4'h4] = 1'b0;
      pg[c[3:0] == 4'h4] = 1'b0;
    end
  endtask : access
  task automatic clash_read(input aes_byte_t c);
    aes_byte_t want;
    xfer(1'b1, 8'h6e, c);
    xfer(1'b1, 8'h6f, 8'h0d);
    want = expect_byte(c, 8'h0d);
    @(negedge clk);
    addr = 8'ha0;
    rd = 1'b1;
    fi = 2'b11;
    pi = 2'b11;
    @(negedge clk);
    rd = 1'b0;
    fi = 2'b00;
    pi = 2'b00;
    check_byte("rdata", want, rdata);
    check_bit("rvalid", 1'b1, rv);
    flt = 2'b11;
    pg = 2'b11;
  endtask : clash_read
  // ==========
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    access(8'h23, 8'h0c);
    access(8'h24, 8'h0d);
    access(8'h43, 8'h0d);
    access(8'h25, 8'h0d);
    xfer(1'b0, 8'h55, 8'h00);
    xfer(1'b0, 8'h6e, 8'h25);
    xfer(1'b0, 8'h6f, 8'h0d);
    clash_read(8'h33);
    access(8'h23, 8'h0d);
    access(8'h24, 8'h0d);
    for (int i = 0; i < 300; i++) begin
      rnd = lfsr(rnd);
      @(negedge clk);
      {an, np, pi, fi} = rnd;
      flt = flt | fi;
      pg = pg | pi;
      @(negedge clk);
      fi = 2'b00;
      pi = 2'b00;
      rnd = lfsr(rnd);
      cr = rnd[6] ? (rnd[7] ? rnd : {3'h1, rnd[4:0]}) : {3'h1, rnd[4], (rnd[0] ? 4'h3 : 4'h4)};
      access(cr, rnd[5] ? 8'h0c : 8'h0d);
      access(rnd[0] ? 8'h23 : 8'h24, 8'h0d);
    end
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule : aes_regs_tb_top
